// file: design/osd_pkg.sv
// package: constants for the off-state output diagnostics block
package osd_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_MHZ = 200;
    // settle times in tenths of a microsecond
    localparam int unsigned SETTLE_N0_DUS = 256;
    localparam int unsigned SETTLE_N1_DUS = 612;
    localparam int unsigned SETTLE_N2_DUS = 1056;
    localparam int unsigned SETTLE_N3_DUS = 1500;
    localparam int unsigned SETTLE_H0_DUS = 112;
    localparam int unsigned SETTLE_H1_DUS = 289;
    localparam int unsigned SETTLE_H2_DUS = 400;
    localparam int unsigned SETTLE_H3_DUS = 512;
    // deglitch window, tenths of a microsecond, least and longest
    localparam int unsigned DEGLITCH_MIN_DUS = 3;
    localparam int unsigned DEGLITCH_MAX_DUS = 5;
    // deglitch count: least time rounded up, stays under the longest
    localparam int unsigned DEGLITCH_CYC = (DEGLITCH_MIN_DUS * CLK_MHZ + 9) / 10;
    localparam logic [7:0]  DEGLITCH_CYC_W = 8'(DEGLITCH_CYC);
    localparam int unsigned TMR_W = 15;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COMP   = 8'h08;
    localparam logic [7:0] ADDR_THRESH = 8'h0c;

    // ctrl fields
    localparam int unsigned CTRL_OCCODE_LSB = 0;  // 6 bits
    localparam int unsigned CTRL_SETTLE_LSB = 8;  // 2 bits
    localparam int unsigned CTRL_HBSHORT    = 10;
    localparam int unsigned CTRL_CURSEL     = 11;
    localparam int unsigned CTRL_RDSEL      = 12;
    localparam int unsigned CTRL_BATT_EN    = 13;
    localparam int unsigned CTRL_TEMP_EN    = 14;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

    // factors are unsigned 1.7 fixed point, one is 8'h80
    localparam logic [7:0] FACTOR_ONE = 8'h80;

    // ****************************************
    // diagnostic codes
    // ****************************************
    typedef enum logic [2:0] {
        DIAG_NO_FAIL  = 3'b100,
        DIAG_OFF_OK   = 3'b110,
        DIAG_OPEN     = 3'b011,
        DIAG_SHORT    = 3'b010
    } osd_code_e;

    typedef enum logic [1:0] {
        CFG_LOW  = 2'b00,
        CFG_HIGH = 2'b01,
        CFG_HB   = 2'b10
    } osd_cfg_e;

endpackage : osd_pkg

// file: design/osd_deglitch.sv
// module: one comparator synchroniser and fixed deglitch filter
`timescale 1ns/100ps
module osd_deglitch
    import osd_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic raw,
    output logic      filt,
    output logic      rise,
    output logic      fall
);
    logic       s1_q, s2_q, s1_d, s2_d;
    logic       filt_q, filt_d;
    logic [7:0] cnt_q, cnt_d;

    always_comb begin
        s1_d  = raw;
        s2_d  = s1_q;
        filt_d = filt_q;
        cnt_d  = 8'h00;
        // new level must hold the window
        if (s2_q != filt_q) begin
            if (cnt_q == DEGLITCH_CYC_W - 8'h01) begin
                filt_d = s2_q;
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            filt_q <= 1'b0;
            cnt_q  <= 8'h00;
        end else begin
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            filt_q <= filt_d;
            cnt_q  <= cnt_d;
        end
    end

    assign filt = filt_q;
    assign rise = filt_d & ~filt_q;
    assign fall = ~filt_d & filt_q;

    a_deglitch_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(filt_q) |-> $past(s2_q, 2) == filt_q)
        else $error("filtered level changed without stable input");

endmodule : osd_deglitch

// file: design/osd_regs.sv
// module: axi4-lite slave holding control and compensation words
`timescale 1ns/100ps
module osd_regs
    import osd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] status_word,
    input  wire logic [31:0] thresh_word,
    output logic [31:0]      ctrl,
    output logic [15:0]      comp,
    output logic             status_read
);
    logic [31:0] ctrl_q, ctrl_d;
    logic [15:0] comp_q, comp_d;
    logic [7:0]  aw_q, aw_d;
    logic        awh_q, awh_d, wh_q, wh_d;
    logic [31:0] wd_q, wd_d;
    logic [3:0]  ws_q, ws_d;
    logic        bv_q, bv_d, rv_q, rv_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    logic [31:0] rd_q, rd_d;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    always_comb begin
        ctrl_d = ctrl_q;
        comp_d = comp_q;
        aw_d = aw_q;
        awh_d = awh_q;
        wh_d = wh_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rr_d = rr_q;
        rd_d = rd_q;
        status_read = 1'b0;
        if (s_axi_awvalid && !awh_q) begin
            awh_d = 1'b1;
            aw_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wh_q) begin
            wh_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (awh_q && wh_q && !bv_q) begin
            awh_d = 1'b0;
            wh_d  = 1'b0;
            bv_d  = 1'b1;
            br_d  = 2'b00;
            unique case (aw_q)
                ADDR_CTRL: ctrl_d = merge(ctrl_q, wd_q, ws_q);
                ADDR_COMP: comp_d = 16'(merge({16'h0000, comp_q}, wd_q, ws_q));
                ADDR_STATUS, ADDR_THRESH: br_d = 2'b00;
                default: br_d = 2'b10;
            endcase
        end
        if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        if (s_axi_arvalid && !rv_q) begin
            rv_d = 1'b1;
            rr_d = 2'b00;
            unique case (s_axi_araddr)
                ADDR_CTRL:   rd_d = ctrl_q;
                ADDR_STATUS: begin
                    rd_d = status_word;
                    status_read = 1'b1;
                end
                ADDR_COMP:   rd_d = {16'h0000, comp_q};
                ADDR_THRESH: rd_d = thresh_word;
                default: begin
                    rd_d = 32'h0000_0000;
                    rr_d = 2'b10;
                end
            endcase
        end
        if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
            comp_q <= {FACTOR_ONE, FACTOR_ONE};
            aw_q <= 8'h00;
            awh_q <= 1'b0;
            wh_q <= 1'b0;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            bv_q <= 1'b0;
            br_q <= 2'b00;
            rv_q <= 1'b0;
            rr_q <= 2'b00;
            rd_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            comp_q <= comp_d;
            aw_q <= aw_d;
            awh_q <= awh_d;
            wh_q <= wh_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rr_q <= rr_d;
            rd_q <= rd_d;
        end
    end

    assign s_axi_awready = !awh_q;
    assign s_axi_wready  = !wh_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rresp   = rr_q;
    assign s_axi_rdata   = rd_q;
    assign ctrl          = ctrl_q;
    assign comp          = comp_q;

endmodule : osd_regs

// file: design/osd_top.sv
// module: off-state diagnostics for one output channel
`timescale 1ns/100ps
module osd_top
    import osd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        channel_on,
    input  wire logic [1:0]  channel_cfg,
    input  wire logic        no_oc_latch,
    input  wire logic        above_low_diag_threshold,
    input  wire logic        above_high_diag_threshold,
    input  wire logic        diag_enable,
    output logic             open_regulator_enable,
    output logic             open_regulator_current_select,
    output logic             fast_discharge_source,
    output logic             fast_charge_source,
    output logic [2:0]       diag_code
);

    // ****************************************
    // reset release
    // ****************************************
    logic rs1_q, rs2_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    logic rst_n;
    assign rst_n = rs2_q;

    // ****************************************
    // registers
    // ****************************************
    logic [31:0] ctrl;
    logic [15:0] comp;
    logic        status_read;
    logic [31:0] status_word;
    logic [31:0] thresh_word;

    osd_regs u_regs (
        .clk           (clk),
        .rst_n         (rst_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .status_word   (status_word),
        .thresh_word   (thresh_word),
        .ctrl          (ctrl),
        .comp          (comp),
        .status_read   (status_read)
    );

    logic [5:0] overcurrent_threshold_code;
    logic [1:0] off_settle_time_select;
    logic       hb_short_set;
    logic       threshold_readback_select;
    assign overcurrent_threshold_code = ctrl[CTRL_OCCODE_LSB +: 6];
    assign off_settle_time_select     = ctrl[CTRL_SETTLE_LSB +: 2];
    assign hb_short_set               = ctrl[CTRL_HBSHORT];
    assign threshold_readback_select  = ctrl[CTRL_RDSEL];

    // ****************************************
    // comparator conditioning
    // ****************************************
    logic lo_f, lo_rise, lo_fall, hi_f, hi_rise, hi_fall;

    osd_deglitch u_lo (
        .clk  (clk),
        .rst_n(rst_n),
        .raw  (above_low_diag_threshold),
        .filt (lo_f),
        .rise (lo_rise),
        .fall (lo_fall)
    );

    osd_deglitch u_hi (
        .clk  (clk),
        .rst_n(rst_n),
        .raw  (above_high_diag_threshold),
        .filt (hi_f),
        .rise (hi_rise),
        .fall (hi_fall)
    );

    // ****************************************
    // settle timer
    // ****************************************
    function automatic logic [TMR_W-1:0] cyc(input int unsigned dus);
        return TMR_W'(dus * CLK_MHZ / 10);
    endfunction : cyc

    logic [TMR_W-1:0] settle_len;
    always_comb begin
        unique case ({channel_cfg == CFG_HB && hb_short_set, off_settle_time_select})
            3'b000: settle_len = cyc(SETTLE_N0_DUS);
            3'b001: settle_len = cyc(SETTLE_N1_DUS);
            3'b010: settle_len = cyc(SETTLE_N2_DUS);
            3'b011: settle_len = cyc(SETTLE_N3_DUS);
            3'b100: settle_len = cyc(SETTLE_H0_DUS);
            3'b101: settle_len = cyc(SETTLE_H1_DUS);
            3'b110: settle_len = cyc(SETTLE_H2_DUS);
            3'b111: settle_len = cyc(SETTLE_H3_DUS);
        endcase
    end

    logic             on_q, on_d;
    logic             run_q, run_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic             expire;
    logic             restart;
    logic             is_high;
    assign is_high = (channel_cfg == CFG_HIGH);

    always_comb begin
        restart = is_high ? (lo_rise | hi_rise) : (lo_fall | hi_fall);
        on_d   = channel_on;
        run_d  = run_q;
        tmr_d  = tmr_q;
        expire = 1'b0;
        if (channel_on) begin
            run_d = 1'b0;
            tmr_d = '0;
        end else if ((on_q && !channel_on) || (restart && !on_q)) begin
            run_d = 1'b1;
            tmr_d = '0;
        end else if (run_q) begin
            if (tmr_q == settle_len - TMR_W'(1)) begin
                run_d  = 1'b0;
                expire = 1'b1;
            end else begin
                tmr_d = tmr_q + TMR_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            on_q  <= 1'b0;
            run_q <= 1'b0;
            tmr_q <= '0;
        end else begin
            on_q  <= on_d;
            run_q <= run_d;
            tmr_q <= tmr_d;
        end
    end

    // ****************************************
    // classification and code latch
    // ****************************************
    logic       is_short, is_open;
    logic [2:0] code_q, code_d;
    logic       fault_q, fault_d;
    logic       nofail_q, nofail_d;

    always_comb begin
        if (is_high) begin
            is_short = hi_f;
        end else begin
            is_short = !lo_f;
        end
        is_open = lo_f && !hi_f;
        code_d   = code_q;
        fault_d  = fault_q;
        nofail_d = nofail_q;
        if (status_read) begin
            fault_d = 1'b0;
            if (!fault_q) begin
                nofail_d = 1'b0;
            end
        end
        if (on_q && !channel_on && no_oc_latch) begin
            nofail_d = 1'b1;
        end
        if (expire) begin
            if (is_short || is_open) begin
                fault_d = 1'b1;
                code_d = is_short ? DIAG_SHORT : DIAG_OPEN;
            end
        end
        if (!fault_d) begin
            code_d = nofail_d ? DIAG_NO_FAIL : DIAG_OFF_OK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_q   <= DIAG_OFF_OK;
            fault_q  <= 1'b0;
            nofail_q <= 1'b0;
        end else begin
            code_q   <= code_d;
            fault_q  <= fault_d;
            nofail_q <= nofail_d;
        end
    end

    assign diag_code   = code_q;
    assign status_word = {16'h0000, 8'(tmr_q[TMR_W-1 -: 8]), 1'b0, run_q, hi_f, lo_f,
                          fault_q, code_q};

    // ****************************************
    // current sources and regulator
    // ****************************************
    // regulator ignores diag_enable
    assign open_regulator_enable = 1'b1;
    assign open_regulator_current_select = ctrl[CTRL_CURSEL];
    assign fast_discharge_source = is_high && !channel_on && run_q && hi_f;
    assign fast_charge_source = (channel_cfg == CFG_LOW) && !channel_on && run_q && !lo_f;

    // ****************************************
    // threshold compensation
    // ****************************************
    logic [7:0]  bcf, temperature_comp_factor;
    logic [21:0] prod;
    logic [5:0]  comp_code;
    assign bcf  = ctrl[CTRL_BATT_EN] ? comp[7:0]  : FACTOR_ONE;
    assign temperature_comp_factor  = ctrl[CTRL_TEMP_EN] ? comp[15:8] : FACTOR_ONE;
    assign prod = 22'(overcurrent_threshold_code) * 22'(bcf) * 22'(temperature_comp_factor);
    assign comp_code = (prod[21:14] > 8'h3f) ? 6'h3f : prod[19:14];
    assign thresh_word = {24'h0, 2'b00,
        threshold_readback_select ? comp_code : overcurrent_threshold_code};

    a_dis_gate: assert property (@(posedge clk) disable iff (!rst_n)
        fast_discharge_source |-> run_q && hi_f && channel_cfg == CFG_HIGH)
        else $error("fast discharge outside its window");
    a_chg_gate: assert property (@(posedge clk) disable iff (!rst_n)
        fast_charge_source |-> run_q && !lo_f && !channel_on)
        else $error("fast charge outside its window");
    // code only changes to fault at expiry
    a_fault_expiry: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(fault_q) |-> $past(expire))
        else $error("fault latched without timer expiry");
    a_fault_code: assert property (@(posedge clk) disable iff (!rst_n)
        fault_q |-> code_q == DIAG_SHORT || code_q == DIAG_OPEN)
        else $error("bad fault code");
    a_off_code: assert property (@(posedge clk) disable iff (!rst_n)
        !fault_q && !nofail_q |-> code_q == DIAG_OFF_OK)
        else $error("wrong normal code");
    a_nofail_once: assert property (@(posedge clk) disable iff (!rst_n)
        on_q && !channel_on && no_oc_latch ##1 !fault_q |-> code_q == DIAG_NO_FAIL)
        else $error("no-failure code missing");
    a_fault_hold: assert property (@(posedge clk) disable iff (!rst_n)
        fault_q && !status_read |=> fault_q)
        else $error("fault dropped without read");
    a_reg_on: assert property (@(posedge clk) disable iff (!rst_n)
        open_regulator_enable)
        else $error("regulator disabled");
    a_readback: assert property (@(posedge clk) disable iff (!rst_n)
        !threshold_readback_select |-> thresh_word[5:0] == overcurrent_threshold_code)
        else $error("readback mismatch");
    a_settle_restart: assert property (@(posedge clk) disable iff (!rst_n)
        !channel_on && (on_q || restart) |=> run_q && tmr_q == '0)
        else $error("settle timer not restarted");

endmodule : osd_top

// file: testbench/osd_node_model.sv
// node model: output node level seen through the two diagnostic comparators
`timescale 1ns/100ps
module osd_node_model (
    input  wire logic [1:0] node_level,
    output logic            above_low_diag_threshold,
    output logic            above_high_diag_threshold
);
    // ****************************************
    // comparators
    // ****************************************
    // level 0 below low, 1 between, 2 above high; ideal tracking thresholds
    assign above_low_diag_threshold  = (node_level != 2'd0);
    assign above_high_diag_threshold = (node_level == 2'd2);
endmodule : osd_node_model

// file: testbench/tb.sv
// testbench: off-state diagnostics through an axi4-lite master and node model
`timescale 1ns/100ps
module tb;
    import osd_pkg::*;
    // ****************************************
    // signals and instances
    // ****************************************
    logic        clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, channel_on, no_oc_latch, diag_enable, s_axi_awready;
    logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        above_low_diag_threshold, above_high_diag_threshold;
    logic        open_regulator_enable, open_regulator_current_select;
    logic        fast_discharge_source, fast_charge_source;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, lf;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  channel_cfg, node_level, s_axi_bresp, s_axi_rresp;
    logic [2:0]  diag_code;
    logic [5:0]  oc;
    logic [33:0] expq[$];
    logic [31:0] mskq[$];
    int          fail_count, checked;
    osd_node_model node (.node_level, .above_low_diag_threshold, .above_high_diag_threshold);
    osd_top dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .channel_on, .channel_cfg, .no_oc_latch,
        .above_low_diag_threshold, .above_high_diag_threshold, .diag_enable,
        .open_regulator_enable, .open_regulator_current_select, .fast_discharge_source,
        .fast_charge_source, .diag_code);
    // ****************************************
    // tasks
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic       aw_ok, w_ok, b_ok;
        logic [1:0] br;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(negedge clk);
            aw_ok = s_axi_awvalid && s_axi_awready;
            w_ok  = s_axi_wvalid && s_axi_wready;
            b_ok  = s_axi_bvalid;
            br    = s_axi_bresp;
            @(posedge clk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end while (!b_ok);
        s_axi_bready <= 1'b0;
        chk(br, er);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [31:0] m);
        logic ar_ok, r_ok;
        expq.push_back(e);
        mskq.push_back(m);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(negedge clk);
            ar_ok = s_axi_arvalid && s_axi_arready;
            r_ok  = s_axi_rvalid;
            @(posedge clk);
            if (ar_ok) s_axi_arvalid <= 1'b0;
        end while (!r_ok);
        s_axi_rready <= 1'b0;
    endtask : rd
    // node held while on, then the channel is switched off
    task automatic burst(input logic [1:0] n);
        @(posedge clk);
        node_level <= n;
        channel_on <= 1'b1;
        repeat (100) @(posedge clk);
        channel_on <= 1'b0;
    endtask : burst
    task automatic complete_run;
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    // ****************************************
    // read monitor, watchdog, clock
    // ****************************************
    always @(negedge clk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready && expq.size() > 0) begin
            chk({s_axi_rresp, s_axi_rdata & mskq[0]}, expq[0]);
            void'(expq.pop_front());
            void'(mskq.pop_front());
        end
    end
    initial begin
        #(5 * 80000);
        fail_count++;
        complete_run();
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, channel_on, no_oc_latch, diag_enable, s_axi_awaddr} = '0;
        {s_axi_araddr, s_axi_wdata, channel_cfg} = '0;
        s_axi_wstrb = 4'hf;
        node_level = 2'd2;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        chk(diag_code, DIAG_OFF_OK);
        lf = lfsr(32'h0001_10b4);
        oc = lf[5:0];
        diag_enable <= lf[0];
        rd(ADDR_COMP, 34'h8080, 32'hffff);
        wr(ADDR_CTRL, 32'(oc) | (32'h1 << CTRL_CURSEL), 2'b00);
        rd(ADDR_CTRL, 34'(oc) | (34'h1 << CTRL_CURSEL), 32'hffff);
        chk(open_regulator_current_select, 1'b1);
        chk(open_regulator_enable, 1'b1);
        rd(8'h10, {2'b10, 32'h0}, 32'hffff_ffff);
        wr(8'h10, lf, 2'b10);
        // temperature compensation off keeps joint use out, as software must
        wr(ADDR_COMP, 32'h0000_5560, 2'b00);
        wr(ADDR_CTRL, 32'(oc) | (32'h1 << CTRL_RDSEL) | (32'h1 << CTRL_BATT_EN), 2'b00);
        rd(ADDR_THRESH, 34'((int'(oc) * 96) >> 7), 32'h3f);
        wr(ADDR_CTRL, 32'(oc), 2'b00);
        rd(ADDR_THRESH, 34'(oc), 32'h3f);
        chk(open_regulator_current_select, 1'b0);
        no_oc_latch <= 1'b1;
        burst(2'd2);
        repeat (5300) @(posedge clk);
        chk(diag_code, DIAG_NO_FAIL);
        no_oc_latch <= 1'b0;
        rd(ADDR_STATUS, 34'(DIAG_NO_FAIL), 32'h7);
        repeat (4) @(posedge clk);
        chk(diag_code, DIAG_OFF_OK);
        burst(2'd0);
        repeat (100) @(posedge clk);
        chk({fast_charge_source, fast_discharge_source}, 2'b10);
        repeat (4000) @(posedge clk);
        chk(diag_code, DIAG_OFF_OK);
        repeat (1200) @(posedge clk);
        chk(diag_code, DIAG_SHORT);
        chk(fast_charge_source, 1'b0);
        node_level <= 2'd2;
        repeat (200) @(posedge clk);
        chk(diag_code, DIAG_SHORT);
        rd(ADDR_STATUS, 34'(DIAG_SHORT), 32'h7);
        repeat (4) @(posedge clk);
        chk(diag_code, DIAG_OFF_OK);
        burst(2'd2);
        repeat (3000) @(posedge clk);
        node_level <= 2'd1;
        repeat (2400) @(posedge clk);
        chk(diag_code, DIAG_OFF_OK);
        repeat (3000) @(posedge clk);
        chk(diag_code, DIAG_OPEN);
        rd(ADDR_STATUS, 34'(DIAG_OPEN), 32'h7);
        channel_cfg <= CFG_HIGH;
        burst(2'd2);
        repeat (100) @(posedge clk);
        chk({fast_charge_source, fast_discharge_source}, 2'b01);
        repeat (5200) @(posedge clk);
        chk(diag_code, DIAG_SHORT);
        rd(ADDR_STATUS, 34'(DIAG_SHORT), 32'h7);
        burst(2'd0);
        repeat (3000) @(posedge clk);
        node_level <= 2'd1;
        repeat (2400) @(posedge clk);
        chk(diag_code, DIAG_OFF_OK);
        repeat (3000) @(posedge clk);
        chk(diag_code, DIAG_OPEN);
        rd(ADDR_STATUS, 34'(DIAG_OPEN), 32'h7);
        channel_cfg <= CFG_HB;
        wr(ADDR_CTRL, 32'(oc) | (32'h1 << CTRL_HBSHORT) | (32'h1 << CTRL_SETTLE_LSB), 2'b00);
        burst(2'd0);
        repeat (1000) @(posedge clk);
        // glitch shorter than the window must not restart the timer
        node_level <= 2'd2;
        repeat (30) @(posedge clk);
        node_level <= 2'd0;
        repeat (4670) @(posedge clk);
        chk(diag_code, DIAG_OFF_OK);
        repeat (200) @(posedge clk);
        chk(diag_code, DIAG_SHORT);
        complete_run();
    end
endmodule : tb
